// *** core/cam_defs.vh ***
`ifndef CAM_DEFS_VH
`define CAM_DEFS_VH
`define CAM_DEPTH     256
`define CAM_ALL_DEV   16'hFFFF
`define CAM_CTL_RST   16'h0000
`define CAM_SEG_RST   8'hCC
`define CAM_POS_RST   16'h0000
`define CAM_NO_HIT    8'hFF
`define CAM_CTL_SWRST 15
`define CAM_CTL_ENH   3
// Command opcodes, word bits 15:12
`define CAM_OP_LDCTL  4'h1
`define CAM_OP_LDSEG  4'h2
`define CAM_OP_LDDEV  4'h3
`define CAM_OP_LDPTR  4'h4
`define CAM_OP_LDPOS  4'h5
`define CAM_OP_SPS    4'h6
`define CAM_OP_SPD    4'h7
`define CAM_OP_MOV    4'h8
`define CAM_OP_MOVI   4'h9
`define CAM_OP_CMP    4'hA
`define CAM_OP_SHC    4'hB
`define CAM_OP_SHM    4'hC
`define CAM_OP_M1SEL  4'hD
// Pending load targets
`define CAM_PL_NONE   3'h0
`define CAM_PL_CTL    3'h1
`define CAM_PL_SEG    3'h2
`define CAM_PL_DEV    3'h3
`define CAM_PL_PTR    3'h4
`define CAM_PL_POS    3'h5
// Persistent source / destination targets
`define CAM_TG_COMP   3'h0
`define CAM_TG_MSK1   3'h1
`define CAM_TG_MSK2   3'h2
`define CAM_TG_MPTR   3'h4
// Validity conditions
`define CAM_V_VALID   2'h0
`define CAM_V_SKIP    2'h1
`define CAM_V_RAND    2'h2
`define CAM_V_EMPTY   2'h3
`endif

// *** core/cam_core.v ***
`timescale 1ns/1ps
`include "cam_defs.vh"
// Summary of operation
// - Data cycles default to the comparand, one segment per cycle.
// - Persistent source and destination commands retarget later data cycles.
// - Auto compare uses valid entries; forced compare uses the given condition.
// - Comparand shift rotates one bit within the compare partition.
// - Mask bit 0 compares the bit; mask bit 1 ignores it.
// - Masked writes update bits with mask 0, keep bits with mask 1.
// - Primary mask has foreground and background copies; foreground after reset.
// - Sliding mask shift replicates the limit bit, no wrap.
// - Entries hold 64 data bits and two validity bits; storage-only data bits do not compare.
// - Control bits 8-6 split compare and storage fields on 16-bit edges.
// - Memory address from instruction, pointer, next empty or best hit.
// - Cycle type decoded from selects sampled at strobe fall.
// - Write data captured at strobe fall; read data driven after it.
// - Transfers take one to four segments, set by segment control.
// - Comparand or mask write at end segment starts auto compare.
// - Control load starts auto compare, except software reset.
// - Forced empty compare masks all data bits.
// - Standard locked chain without hit keeps outputs off.
// - Enhanced mode accepts writes while chain locked.
// - Device select all-ones enables writes in every device unless the chain is locked.
// - Best-hit operations only in the top matching device.
// - Chain hit and full outputs merge incoming and local state.
// - Chain enable latched at strobe fall, applied at strobe rise.
// - Device selected when device select equals position id.
// - Top device has incoming hit high and own hit present.
module cam_core (
  // System
  input  wire        clk,
  input  wire        sys_rst,
  // Host strobe bus
  input  wire        cycle_strobe_n,
  input  wire        write_sel_n,
  input  wire        command_select_n,
  input  wire [15:0] data_bus_pins_in,
  output reg  [15:0] data_bus_pins_out,
  output reg         data_bus_pins_oe_n,
  // Cascade chain
  input  wire        chain_enable_ctrl_n,
  input  wire        chain_hit_in_n,
  input  wire        full_chain_in_n,
  output reg         chain_hit_out_n,
  output reg         full_chain_out_n,
  output reg         local_hit_flag_n
);
  reg  [21:0] sy1;
  reg  [21:0] sy2;
  reg         stb_d;
  reg  [63:0] comp;
  reg  [63:0] msk1_fg;
  reg  [63:0] msk1_bg;
  reg  [63:0] msk2;
  reg         msk1_bgsel;
  reg  [15:0] ctl;
  reg  [15:0] dev_sel;
  reg  [15:0] pos_id;
  reg  [7:0]  seg;
  reg  [1:0]  dseg;
  reg  [1:0]  sseg;
  reg  [2:0]  pdst;
  reg  [2:0]  psrc;
  reg  [1:0]  pdst_msel;
  reg  [2:0]  pend;
  reg  [7:0]  addr_ptr;
  reg  [7:0]  best_hit;
  reg         local_hit;
  reg         multi;
  reg         cmp_go;
  reg  [1:0]  cmp_cond;
  reg  [1:0]  last_vld;
  reg         ec_lat;
  reg         ec_int;
  reg  [63:0] mem_data [0:`CAM_DEPTH-1];
  reg  [1:0]  mem_vld  [0:`CAM_DEPTH-1];
  integer     r;

  // Pins pass two flops; the third stage only feeds edge detection
  wire        stb   = sy2[21];
  wire        wr_n  = sy2[20];
  wire        cm_n  = sy2[19];
  wire        ec_n  = sy2[18];
  wire        mi_n  = sy2[17];
  wire        fi_n  = sy2[16];
  wire [15:0] din   = sy2[15:0];
  wire        fall  = stb_d & ~stb;
  wire        rise  = ~stb_d & stb;
  wire [3:0]  op    = din[15:12];

  // Returns {low limit, high limit} of the compare field
  function [11:0] cam_lim;
    input [2:0] code;
    begin
      case (code)
        3'b001:  cam_lim = {6'd16, 6'd63};
        3'b010:  cam_lim = {6'd32, 6'd63};
        3'b011:  cam_lim = {6'd48, 6'd63};
        3'b100:  cam_lim = {6'd0, 6'd47};
        3'b101:  cam_lim = {6'd0, 6'd31};
        3'b110:  cam_lim = {6'd0, 6'd15};
        default: cam_lim = {6'd0, 6'd63};
      endcase
    end
  endfunction

  wire [11:0] lim = cam_lim(ctl[8:6]);
  wire [5:0]  lo  = lim[11:6];
  wire [5:0]  hi  = lim[5:0];
  wire [63:0] msk1_act = msk1_bgsel ? msk1_bg : msk1_fg;

  function [63:0] msel_f;
    input [1:0] s;
    begin
      case (s)
        2'h1:    msel_f = msk1_act;
        2'h2:    msel_f = msk2;
        default: msel_f = 64'h0;
      endcase
    end
  endfunction

  // Lowest set bit wins, giving {found, index}
  function [8:0] first_set;
    input [`CAM_DEPTH-1:0] v;
    integer k;
    begin
      first_set = {1'b0, `CAM_NO_HIT};
      for (k = `CAM_DEPTH - 1; k >= 0; k = k - 1)
        if (v[k])
          first_set = {1'b1, k[7:0]};
    end
  endfunction

  wire [63:0] field;
  wire [63:0] comp_sr;
  wire [63:0] comp_sl;
  wire [63:0] m2_sr;
  wire [63:0] m2_sl;
  wire [63:0] comp_rr = {comp[0], comp[63:1]};
  wire [63:0] comp_rl = {comp[62:0], comp[63]};
  wire [63:0] m2_rr   = {msk2[0], msk2[63:1]};
  wire [63:0] m2_rl   = {msk2[62:0], msk2[63]};
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1)
    begin : g_bit
      localparam [31:0] BI = g;
      localparam [5:0]  B  = BI[5:0];
      assign field[g]   = (B >= lo) && (B <= hi);
      assign comp_sr[g] = !field[g] ? comp[g] : (B == hi ? comp[lo] : comp_rr[g]);
      assign comp_sl[g] = !field[g] ? comp[g] : (B == lo ? comp[hi] : comp_rl[g]);
      assign m2_sr[g]   = !field[g] ? msk2[g] : (B == hi ? msk2[g] : m2_rr[g]);
      assign m2_sl[g]   = !field[g] ? msk2[g] : (B == lo ? msk2[g] : m2_rl[g]);
    end
  endgenerate

  // Storage-only bits never take part in a compare
  wire [63:0] cmask = (cmp_cond == `CAM_V_EMPTY) ? 64'hFFFFFFFFFFFFFFFF
                      : (msel_f(ctl[5:4]) | ~field);
  wire [`CAM_DEPTH-1:0] hit_v;
  wire [`CAM_DEPTH-1:0] empty_v;
  generate
    for (g = 0; g < `CAM_DEPTH; g = g + 1)
    begin : g_ent
      assign hit_v[g]   = (mem_vld[g] == cmp_cond) &&
                          (((mem_data[g] ^ comp) & ~cmask) == 64'h0);
      assign empty_v[g] = mem_vld[g] == `CAM_V_EMPTY;
    end
  endgenerate
  wire [8:0]  hit_f      = first_set(hit_v);
  wire [8:0]  free_f     = first_set(empty_v);
  wire [`CAM_DEPTH-1:0] hv_m1 = hit_v - {{(`CAM_DEPTH-1){1'b0}}, 1'b1};
  wire        multi_hit  = |(hit_v & hv_m1);
  wire        local_full = ~free_f[8];
  wire [7:0]  free_idx   = free_f[7:0];

  wire sel_all = dev_sel == `CAM_ALL_DEV;
  wire sel_me  = dev_sel == pos_id;
  wire top_hit = mi_n & local_hit;
  wire nf_here = ~fi_n & ~local_full;
  wire wr_ok   = ec_int ? (sel_all | sel_me) : (top_hit | ctl[`CAM_CTL_ENH]);
  wire rd_ok   = ec_int ? sel_me : top_hit;

  function [7:0] addr_of;
    input [1:0] mode;
    begin
      case (mode)
        2'h1:    addr_of = free_idx;
        2'h2:    addr_of = best_hit;
        default: addr_of = addr_ptr;
      endcase
    end
  endfunction

  function mode_ok;
    input [1:0] mode;
    begin
      case (mode)
        2'h1:    mode_ok = nf_here;
        2'h2:    mode_ok = top_hit;
        default: mode_ok = 1'b1;
      endcase
    end
  endfunction

  wire [7:0]  dst_addr = addr_of(pdst[1:0]);
  wire [7:0]  src_addr = addr_of(psrc[1:0]);
  wire [63:0] dst_m    = msel_f(pdst_msel);
  wire [15:0] wm       = dst_m[{dseg, 4'h0} +: 16];
  wire [63:0] dst_word = mem_data[dst_addr];
  wire [15:0] dst_old  = dst_word[{dseg, 4'h0} +: 16];
  wire [15:0] dst_new  = (dst_old & wm) | (din & ~wm);
  wire [63:0] src_word = mem_data[src_addr];
  wire [7:0]  mv_addr  = (op == `CAM_OP_MOVI) ? din[7:0] : addr_of(din[1:0]);
  wire        mv_dir   = (op == `CAM_OP_MOVI) ? din[8] : din[2];
  wire [63:0] mv_m     = msel_f((op == `CAM_OP_MOVI) ? din[10:9] : din[4:3]);
  wire [1:0]  mv_v     = (op == `CAM_OP_MOVI) ? `CAM_V_VALID : din[6:5];
  wire        mv_ok    = (op == `CAM_OP_MOVI) | mode_ok(din[1:0]);
  wire [63:0] mv_word  = mem_data[mv_addr];
  wire [63:0] src_sel  = psrc[2] ? src_word : (psrc == `CAM_TG_MSK1) ? msk1_act
                         : (psrc == `CAM_TG_MSK2) ? msk2 : comp;
  wire [15:0] status   = {~local_full, ~multi, last_vld, 3'h0, best_hit, ~local_hit};

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sy1 <= 22'h3FFFFF;
      sy2 <= 22'h3FFFFF;
      stb_d <= 1'b1;
      data_bus_pins_out <= 16'h0000;
      data_bus_pins_oe_n <= 1'b1;
      chain_hit_out_n <= 1'b1;
      full_chain_out_n <= 1'b1;
      local_hit_flag_n <= 1'b1;
      comp <= 64'h0;
      msk1_fg <= 64'h0;
      msk1_bg <= 64'h0;
      msk2 <= 64'h0;
      msk1_bgsel <= 1'b0;
      ctl <= `CAM_CTL_RST;
      dev_sel <= `CAM_ALL_DEV;
      pos_id <= `CAM_POS_RST;
      seg <= `CAM_SEG_RST;
      dseg <= 2'h0;
      sseg <= 2'h0;
      pdst <= `CAM_TG_COMP;
      psrc <= `CAM_TG_COMP;
      pdst_msel <= 2'h0;
      pend <= `CAM_PL_NONE;
      addr_ptr <= 8'h00;
      best_hit <= `CAM_NO_HIT;
      local_hit <= 1'b0;
      multi <= 1'b0;
      cmp_go <= 1'b0;
      cmp_cond <= `CAM_V_VALID;
      last_vld <= 2'h3;
      ec_lat <= 1'b1;
      ec_int <= 1'b1;
      for (r = 0; r < `CAM_DEPTH; r = r + 1)
        mem_vld[r] <= `CAM_V_EMPTY;
    end
    else
    begin
      sy1 <= {cycle_strobe_n, write_sel_n, command_select_n, chain_enable_ctrl_n,
              chain_hit_in_n, full_chain_in_n, data_bus_pins_in};
      sy2 <= sy1;
      stb_d <= stb;
      cmp_go <= 1'b0;
      chain_hit_out_n <= mi_n & ~local_hit;
      full_chain_out_n <= ~(~fi_n & local_full);
      local_hit_flag_n <= ~local_hit;
      // Results land one cycle after the compare is requested
      if (cmp_go)
      begin
        local_hit <= hit_f[8];
        best_hit <= hit_f[7:0];
        multi <= multi_hit;
      end
      if (rise)
      begin
        ec_int <= ec_lat;
        data_bus_pins_oe_n <= 1'b1;
      end
      if (fall)
      begin
        ec_lat <= ec_n;
        case ({wr_n, cm_n})
          2'b01:
          begin
            if (wr_ok && (!pdst[2] || mode_ok(pdst[1:0])))
            begin
              case (pdst)
                `CAM_TG_COMP: comp[{dseg, 4'h0} +: 16] <= din;
                `CAM_TG_MSK1:
                  if (msk1_bgsel)
                    msk1_bg[{dseg, 4'h0} +: 16] <= din;
                  else
                    msk1_fg[{dseg, 4'h0} +: 16] <= din;
                `CAM_TG_MSK2: msk2[{dseg, 4'h0} +: 16] <= din;
                default: mem_data[dst_addr][{dseg, 4'h0} +: 16] <= dst_new;
              endcase
              if (dseg == seg[3:2])
              begin
                dseg <= seg[1:0];
                if (!pdst[2])
                begin
                  cmp_go <= 1'b1;
                  cmp_cond <= `CAM_V_VALID;
                end
              end
              else
                dseg <= dseg + 2'h1;
            end
          end
          2'b11:
          begin
            if (rd_ok && (!psrc[2] || mode_ok(psrc[1:0])))
            begin
              data_bus_pins_out <= src_sel[{sseg, 4'h0} +: 16];
              data_bus_pins_oe_n <= 1'b0;
              if (psrc[2])
                last_vld <= mem_vld[src_addr];
              sseg <= (sseg == seg[7:6]) ? seg[5:4] : sseg + 2'h1;
            end
          end
          2'b10:
          begin
            if (rd_ok)
            begin
              data_bus_pins_out <= status;
              data_bus_pins_oe_n <= 1'b0;
            end
          end
          default:
          begin
            if (pend != `CAM_PL_NONE)
            begin
              pend <= `CAM_PL_NONE;
              // Device select loads in every device; position only at the free slot
              if (pend == `CAM_PL_DEV)
                dev_sel <= din;
              else if (pend == `CAM_PL_POS)
              begin
                if (nf_here)
                  pos_id <= din;
              end
              else if (wr_ok)
              begin
                case (pend)
                  `CAM_PL_CTL:
                    if (din[`CAM_CTL_SWRST])
                    begin
                      ctl <= `CAM_CTL_RST;
                      seg <= `CAM_SEG_RST;
                      dseg <= 2'h0;
                      sseg <= 2'h0;
                      pdst <= `CAM_TG_COMP;
                      psrc <= `CAM_TG_COMP;
                      addr_ptr <= 8'h00;
                      msk1_bgsel <= 1'b0;
                    end
                    else
                    begin
                      ctl <= din;
                      cmp_go <= 1'b1;
                      cmp_cond <= `CAM_V_VALID;
                    end
                  `CAM_PL_SEG:
                  begin
                    seg <= din[7:0];
                    dseg <= din[1:0];
                    sseg <= din[5:4];
                  end
                  default: addr_ptr <= din[7:0];
                endcase
              end
            end
            else if (wr_ok || op == `CAM_OP_LDDEV || op == `CAM_OP_LDPOS)
            begin
              case (op)
                `CAM_OP_LDCTL, `CAM_OP_LDSEG, `CAM_OP_LDDEV, `CAM_OP_LDPTR, `CAM_OP_LDPOS:
                  pend <= din[14:12];
                `CAM_OP_SPS: psrc <= din[2:0];
                `CAM_OP_SPD:
                begin
                  pdst <= din[2:0];
                  pdst_msel <= din[4:3];
                end
                `CAM_OP_MOV, `CAM_OP_MOVI:
                begin
                  if (op == `CAM_OP_MOVI)
                    addr_ptr <= din[7:0];
                  if (mv_ok && !mv_dir)
                  begin
                    mem_data[mv_addr] <= (mv_word & mv_m) | (comp & ~mv_m);
                    mem_vld[mv_addr] <= mv_v;
                  end
                  else if (mv_ok)
                  begin
                    comp <= (comp & mv_m) | (mv_word & ~mv_m);
                    last_vld <= mem_vld[mv_addr];
                  end
                end
                `CAM_OP_CMP:
                begin
                  cmp_go <= 1'b1;
                  cmp_cond <= din[1:0];
                end
                `CAM_OP_SHC: comp <= din[0] ? comp_sl : comp_sr;
                `CAM_OP_SHM: msk2 <= din[0] ? m2_sl : m2_sr;
                `CAM_OP_M1SEL: msk1_bgsel <= din[0];
                default: pend <= `CAM_PL_NONE;
              endcase
            end
          end
        endcase
      end
    end
  end
endmodule

// *** bench/cam_core_checker.sv ***
`timescale 1ns/1ps
module cam_core_checker (
  // System
  input wire logic        clk,
  input wire logic        sys_rst,
  // Host strobe bus
  input wire logic        cycle_strobe_n,
  input wire logic        write_sel_n,
  input wire logic        command_select_n,
  input wire logic [15:0] data_bus_pins_in,
  input wire logic [15:0] data_bus_pins_out,
  input wire logic        data_bus_pins_oe_n,
  // Cascade chain
  input wire logic        chain_enable_ctrl_n,
  input wire logic        chain_hit_in_n,
  input wire logic        full_chain_in_n,
  input wire logic        chain_hit_out_n,
  input wire logic        full_chain_out_n,
  input wire logic        local_hit_flag_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Pins pass two sync flops and the output flop, so the bus answers three samples later
  a_oe_after_fall: assert property (!data_bus_pins_oe_n |-> !$past(cycle_strobe_n, 3))
    else $error("bus driven without a strobe low three clocks before");
  a_write_no_drive: assert property (!data_bus_pins_oe_n |-> $past(write_sel_n, 3))
    else $error("bus driven during a write cycle");
  a_oe_turn_on: assert property ($fell(data_bus_pins_oe_n)
    |-> !$past(cycle_strobe_n, 3) && $past(cycle_strobe_n, 4))
    else $error("bus turned on at the wrong clock after strobe fall");
  a_oe_release: assert property ($rose(data_bus_pins_oe_n)
    |-> $past(cycle_strobe_n, 3) && !$past(cycle_strobe_n, 4))
    else $error("bus released at the wrong clock after strobe rise");
  a_read_data_stable: assert property (!data_bus_pins_oe_n
    && !$past(data_bus_pins_oe_n) |-> $stable(data_bus_pins_out))
    else $error("read data changed while driven");
  a_hit_timing: assert property ($changed(local_hit_flag_n)
    |-> !$past(cycle_strobe_n, 5) && $past(cycle_strobe_n, 6))
    else $error("hit flag moved without a strobe fall five clocks before");
  a_hit_out_local: assert property (!local_hit_flag_n [*3] |-> !chain_hit_out_n)
    else $error("local hit not passed to chain output");
  // Chain inputs reach the outputs three samples later, so four samples must agree
  a_hit_in_pass: assert property (!chain_hit_in_n [*4] |-> !chain_hit_out_n)
    else $error("upstream hit not passed to chain output");
  a_hit_out_quiet: assert property ((chain_hit_in_n && local_hit_flag_n) [*4]
    |-> chain_hit_out_n)
    else $error("chain hit output low without any hit");
  a_full_pass: assert property (full_chain_in_n [*4] |-> full_chain_out_n)
    else $error("full output low while upstream has room");

  c_read: cover property ($fell(data_bus_pins_oe_n));
  c_hit: cover property ($fell(local_hit_flag_n));
  c_chain_hit: cover property (!chain_hit_in_n ##2 !chain_hit_out_n);
endmodule

bind cam_core cam_core_checker i_cam_core_checker (
  .clk                (clk),
  .sys_rst            (sys_rst),
  .cycle_strobe_n     (cycle_strobe_n),
  .write_sel_n        (write_sel_n),
  .command_select_n   (command_select_n),
  .data_bus_pins_in   (data_bus_pins_in),
  .data_bus_pins_out  (data_bus_pins_out),
  .data_bus_pins_oe_n (data_bus_pins_oe_n),
  .chain_enable_ctrl_n(chain_enable_ctrl_n),
  .chain_hit_in_n     (chain_hit_in_n),
  .full_chain_in_n    (full_chain_in_n),
  .chain_hit_out_n    (chain_hit_out_n),
  .full_chain_out_n   (full_chain_out_n),
  .local_hit_flag_n   (local_hit_flag_n)
);

// *** bench/cam_host_model.sv ***
`timescale 1ns/1ps
module cam_host_model (
  // Clock
  input  wire        clk,
  // Strobe bus
  output reg         cycle_strobe_n,
  output reg         write_sel_n,
  output reg         command_select_n,
  output reg         chain_enable_ctrl_n,
  output wire [15:0] data_bus_pins_in,
  input  wire [15:0] data_bus_pins_out,
  input  wire        data_bus_pins_oe_n
);
  reg [15:0] host_val;
  reg        host_drv;
  // A released bus shows the inverse of the last level, never a kept value
  assign data_bus_pins_in = !data_bus_pins_oe_n ? data_bus_pins_out :
                            (host_drv ? host_val : ~host_val);
  initial
  begin
    cycle_strobe_n = 1'b1;
    write_sel_n = 1'b1;
    command_select_n = 1'b1;
    chain_enable_ctrl_n = 1'b1;
    host_val = 16'h0000;
    host_drv = 1'b0;
  end
  // Strobe held low then high for 8 clocks each, twice the minimum
  task cyc(input w, input c, input e, input [15:0] d, output [15:0] q, output got);
    integer i;
    begin
      got = 1'b0;
      q = 16'h0000;
      @(negedge clk);
      write_sel_n = w;
      command_select_n = c;
      chain_enable_ctrl_n = e;
      host_val = d;
      host_drv = !w;
      cycle_strobe_n = 1'b0;
      for (i = 0; i < 16; i = i + 1)
      begin
        @(negedge clk);
        if (data_bus_pins_oe_n === 1'b0)
        begin
          got = 1'b1;
          q = data_bus_pins_out;
        end
        if (i == 7)
        begin
          cycle_strobe_n = 1'b1;
          host_drv = 1'b0;
          host_val = w ? q : host_val;
        end
      end
    end
  endtask
endmodule

// *** bench/cam_compare_and_cascade_tb.sv ***
`timescale 1ns/1ps
`define TB_CHK(a, b) \
  begin \
    n_tests = n_tests + 1; \
    if ((a) !== (b)) \
    begin \
      num_errors = num_errors + 1; \
      $display("MISMATCH at %0t: got %h expected %h", $time, (a), (b)); \
    end \
  end
module cam_compare_and_cascade_tb;
  reg         clk;
  reg         sys_rst;
  reg         chain_hit_in_n;
  reg         full_chain_in_n;
  wire        strobe_n;
  wire        wsel_n;
  wire        csel_n;
  wire        ec_n;
  wire [15:0] din;
  wire [15:0] dout;
  wire        oe_n;
  wire        hit_out_n;
  wire        full_out_n;
  wire        lhit_n;
  integer     num_errors;
  integer     n_tests;
  integer     k;
  reg  [15:0] q;
  reg         got;
  reg  [63:0] v;
  reg  [63:0] x;
  localparam [63:0] KEY = 64'h1234_5678_9ABC_DEF0;

  cam_core i_cam_core (.clk(clk), .sys_rst(sys_rst), .cycle_strobe_n(strobe_n),
    .write_sel_n(wsel_n), .command_select_n(csel_n), .data_bus_pins_in(din),
    .data_bus_pins_out(dout), .data_bus_pins_oe_n(oe_n), .chain_enable_ctrl_n(ec_n),
    .chain_hit_in_n(chain_hit_in_n), .full_chain_in_n(full_chain_in_n),
    .chain_hit_out_n(hit_out_n), .full_chain_out_n(full_out_n), .local_hit_flag_n(lhit_n));
  cam_host_model i_cam_host_model (.clk(clk), .cycle_strobe_n(strobe_n), .write_sel_n(wsel_n),
    .command_select_n(csel_n), .chain_enable_ctrl_n(ec_n), .data_bus_pins_in(din),
    .data_bus_pins_out(dout), .data_bus_pins_oe_n(oe_n));

  always #4 clk = ~clk;

  task bus(input w, input c, input e, input [15:0] d);
    i_cam_host_model.cyc(w, c, e, d, q, got);
  endtask
  task cw(input [15:0] d);
    bus(1'b0, 1'b0, 1'b1, d);
  endtask
  task rd_data;
    for (k = 0; k < 4; k = k + 1)
    begin
      bus(1'b1, 1'b1, 1'b1, 16'h0000);
      v[16*k +: 16] = q;
    end
  endtask
  task wr_data(input [63:0] d);
    for (k = 0; k < 4; k = k + 1)
      bus(1'b0, 1'b1, 1'b1, d[16*k +: 16]);
  endtask
  task tally_and_finish;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task t_select;
    begin
      bus(1'b1, 1'b0, 1'b1, 16'h0000);
      `TB_CHK(got, 1'b0)
      cw(16'h3000);
      cw(16'h0000);
      bus(1'b1, 1'b0, 1'b1, 16'h0000);
      `TB_CHK(got, 1'b1)
      `TB_CHK(q[8:0], 9'h1FF)
    end
  endtask
  task t_segments;
    begin
      wr_data(64'h8000_0000_0000_0001);
      cw(16'h2000);
      cw(16'h0099);
      bus(1'b0, 1'b1, 1'b1, 16'hAAAA);
      bus(1'b0, 1'b1, 1'b1, 16'hBBBB);
      bus(1'b1, 1'b1, 1'b1, 16'h0000);
      `TB_CHK(q, 16'hAAAA)
      cw(16'h2000);
      cw(16'h00CC);
      rd_data;
      `TB_CHK(v, 64'h8000_BBBB_AAAA_0001)
    end
  endtask
  task t_shift;
    begin
      x = 64'h8000_BBBB_AAAA_0001;
      cw(16'hB000);
      rd_data;
      x = {x[0], x[63:1]};
      `TB_CHK(v, x)
      cw(16'h1000);
      cw(16'h0040);
      cw(16'hB001);
      rd_data;
      `TB_CHK(v, {x[62:16], x[63], x[15:0]})
      cw(16'h1000);
      cw(16'h0000);
    end
  endtask
  task t_sliding;
    begin
      cw(16'h7002);
      cw(16'h6002);
      wr_data(64'h8000_0000_0000_0001);
      cw(16'hC001);
      rd_data;
      `TB_CHK(v, 64'h0000_0000_0000_0003)
      cw(16'hC000);
      rd_data;
      `TB_CHK(v, 64'h0000_0000_0000_0001)
      cw(16'h7000);
      cw(16'h6000);
    end
  endtask
  task t_bg_mask;
    begin
      cw(16'h7001);
      cw(16'h6001);
      cw(16'hD001);
      wr_data(64'hF0F0_0000_0000_0F0F);
      cw(16'hD000);
      rd_data;
      `TB_CHK(v, 64'h0000_0000_0000_0000)
      cw(16'hD001);
      rd_data;
      `TB_CHK(v, 64'hF0F0_0000_0000_0F0F)
      cw(16'hD000);
      cw(16'h7000);
      cw(16'h6000);
    end
  endtask
  task t_compare;
    reg [8:0] exp_hit [0:3];
    begin
      exp_hit[0] = 9'h006;
      exp_hit[1] = 9'h1FF;
      exp_hit[2] = 9'h1FF;
      exp_hit[3] = 9'h000;
      wr_data(KEY);
      cw(16'h9007);
      cw(16'h9003);
      cw(16'h9005);
      wr_data(KEY);
      `TB_CHK(lhit_n, 1'b0)
      `TB_CHK(hit_out_n, 1'b0)
      bus(1'b1, 1'b0, 1'b1, 16'h0000);
      `TB_CHK(q[14:0] & 15'h41FF, 15'h0006)
      wr_data(KEY ^ 64'h1);
      `TB_CHK(lhit_n, 1'b1)
      cw(16'h7001);
      wr_data(64'h1);
      cw(16'h7000);
      cw(16'h1000);
      cw(16'h0010);
      `TB_CHK(lhit_n, 1'b0)
      for (k = 0; k < 4; k = k + 1)
      begin
        cw(16'hA000 | k[15:0]);
        bus(1'b1, 1'b0, 1'b1, 16'h0000);
        `TB_CHK(q[8:0], exp_hit[k])
      end
      cw(16'h9203);
      wr_data(64'h0);
      cw(16'h9103);
      rd_data;
      `TB_CHK(v, KEY)
    end
  endtask
  task t_direct;
    begin
      // Entry 3 is both the best hit and the pointer target here
      cw(16'hA000);
      cw(16'h700E);
      wr_data(64'hFFFF_FFFF_FFFF_FFFF);
      cw(16'h6004);
      rd_data;
      `TB_CHK(v, 64'hFFFF_FFFF_FFFF_FFFE)
      // A hit further up the chain must keep this device off its best hit
      chain_hit_in_n = 1'b0;
      wr_data(64'h0);
      chain_hit_in_n = 1'b1;
      rd_data;
      `TB_CHK(v, 64'hFFFF_FFFF_FFFF_FFFE)
      cw(16'h7000);
      cw(16'h6000);
    end
  endtask
  task t_lock(input enh);
    begin
      cw(16'h1000);
      cw(enh ? 16'h0018 : 16'h0010);
      bus(1'b0, 1'b0, 1'b0, 16'hA001);
      bus(1'b1, 1'b0, 1'b0, 16'h0000);
      `TB_CHK(got, 1'b0)
      for (k = 0; k < 4; k = k + 1)
        bus(1'b0, 1'b1, 1'b0, 16'h5555);
      bus(1'b1, 1'b1, 1'b1, 16'h0000);
      rd_data;
      `TB_CHK(v, enh ? 64'h5555_5555_5555_5555 : KEY)
    end
  endtask
  task t_full;
    begin
      // Entries 3, 5 and 7 already hold keys, so 253 moves fill the device
      for (k = 0; k < 252; k = k + 1)
        cw(16'h8001);
      `TB_CHK(full_out_n, 1'b1)
      cw(16'h8001);
      `TB_CHK(full_out_n, 1'b0)
      bus(1'b1, 1'b0, 1'b1, 16'h0000);
      `TB_CHK(q[15], 1'b0)
    end
  endtask
  task t_chain;
    begin
      chain_hit_in_n = 1'b0;
      repeat (4) @(negedge clk);
      `TB_CHK(hit_out_n, 1'b0)
      chain_hit_in_n = 1'b1;
      full_chain_in_n = 1'b1;
      repeat (5) @(negedge clk);
      `TB_CHK(hit_out_n, 1'b1)
      `TB_CHK(full_out_n, 1'b1)
    end
  endtask

  initial
  begin
    #200000;
    num_errors = num_errors + 1;
    tally_and_finish;
  end
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    chain_hit_in_n = 1'b1;
    full_chain_in_n = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_select;
    t_segments;
    t_shift;
    t_sliding;
    t_bg_mask;
    t_compare;
    t_direct;
    t_lock(1'b0);
    t_lock(1'b1);
    t_full;
    t_chain;
    tally_and_finish;
  end
endmodule
